// ### icf_top.sv
// interrupt control and flag register bank with Avalon-MM slave
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module icf_top (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire icf_pkg::icf_trap_t trap_taken,
  input  wire logic              timed_disable_in,
  input  wire icf_pkg::icf_flags_t periph_req,
  input  wire logic [2:0]        ext_pin,
  input  wire logic              handler_active,
  input  wire logic              new_irq_req,
  output logic                   preempt_allow,
  output logic                   alt_vector_select,
  output logic                   nesting_disable,
  output logic [2:0]             cpu_priority_level,
  output icf_pkg::icf_flags_t    pending_flags
);
  logic [15:0] ctrl1;
  logic [15:0] ctrl2;
  logic [2:0]  ext_prev;
  logic [2:0]  ext_edge;
  logic        ack_done;
  logic        wr_ok;
  logic [15:0] wmask;
  logic [15:0] wdata;
  logic [15:0] ctrl2_rd;
  logic [15:0] next_flag0;
  logic [15:0] next_flag1;
  logic [15:0] next_flag2;
  logic [15:0] set0;
  logic [15:0] set1;

  // one wait cycle per access keeps read data registered
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_done;
  assign wr_ok = avs_write & ~ack_done;
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wdata = avs_writedata[15:0];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_done <= 1'b0;
    end else begin
      ack_done <= (avs_read | avs_write) & ~ack_done;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ext_prev <= 3'h0;
    end else begin
      ext_prev <= ext_pin;
    end
  end

  // edge select per input: polarity one watches the falling edge
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ext_edge[i] = ctrl2[i] ? (ext_prev[i] & ~ext_pin[i])
                             : (~ext_prev[i] & ext_pin[i]);
    end
  end

  // trap status: trap sets win over a software clear in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl1 <= icf_pkg::RESET_VAL;
    end else begin
      ctrl1 <= (((wr_ok && avs_address == {1'b0, icf_pkg::ADDR_CTRL1})
                 ? ((ctrl1 & ~wmask) | (wdata & wmask)) : ctrl1)
                | {11'h000, trap_taken, 1'b0}) & icf_pkg::CTRL1_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl2 <= icf_pkg::RESET_VAL;
    end else if (wr_ok && avs_address == {1'b0, icf_pkg::ADDR_CTRL2}) begin
      ctrl2 <= ((ctrl2 & ~wmask) | (wdata & wmask)) & icf_pkg::CTRL2_WMASK;
    end
  end

  assign ctrl2_rd = {ctrl2[15], timed_disable_in, ctrl2[13:0]};

  // priority level: writes ignored while nesting is disabled
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_priority_level <= icf_pkg::PRIO_RESET;
    end else if (wr_ok && avs_address == icf_pkg::ADDR_PRIO && avs_byteenable[0]
                 && !ctrl1[icf_pkg::NEST_BIT]) begin
      cpu_priority_level <= avs_writedata[2:0];
    end
  end

  assign set0 = periph_req.flags0 | {15'h0000, ext_edge[0]};
  assign set1 = periph_req.flags1 | {2'h0, ext_edge[2], 8'h00, ext_edge[1], 4'h0};

  // flags: software write may clear, hardware set always wins
  always_comb begin
    next_flag0 = pending_flags.flags0;
    next_flag1 = pending_flags.flags1;
    next_flag2 = pending_flags.flags2;
    if (wr_ok && avs_address == {1'b0, icf_pkg::ADDR_FLAG0}) begin
      next_flag0 = (next_flag0 & ~wmask) | (wdata & wmask);
    end
    if (wr_ok && avs_address == {1'b0, icf_pkg::ADDR_FLAG1}) begin
      next_flag1 = (next_flag1 & ~wmask) | (wdata & wmask);
    end
    if (wr_ok && avs_address == icf_pkg::ADDR_FLAG2) begin
      next_flag2 = (next_flag2 & ~wmask) | (wdata & wmask);
    end
    next_flag0 = (next_flag0 | set0) & icf_pkg::FLAG0_MASK;
    next_flag1 = (next_flag1 | set1) & icf_pkg::FLAG1_MASK;
    next_flag2 = (next_flag2 | periph_req.flags2) & icf_pkg::FLAG2_MASK;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pending_flags <= '0;
    end else begin
      pending_flags <= {next_flag0, next_flag1, next_flag2};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_done) begin
      case (avs_address)
        {1'b0, icf_pkg::ADDR_CTRL1}: avs_readdata <= {16'h0000, ctrl1};
        {1'b0, icf_pkg::ADDR_CTRL2}: avs_readdata <= {16'h0000, ctrl2_rd};
        {1'b0, icf_pkg::ADDR_FLAG0}: avs_readdata <= {16'h0000, pending_flags.flags0};
        {1'b0, icf_pkg::ADDR_FLAG1}: avs_readdata <= {16'h0000, pending_flags.flags1};
        icf_pkg::ADDR_FLAG2:         avs_readdata <= {16'h0000, pending_flags.flags2};
        icf_pkg::ADDR_PRIO:          avs_readdata <= {29'h0000_0000, cpu_priority_level};
        default:                     avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  assign nesting_disable   = ctrl1[icf_pkg::NEST_BIT];
  assign preempt_allow     = new_irq_req & ~(handler_active & ctrl1[icf_pkg::NEST_BIT]);
  assign alt_vector_select = ctrl2[icf_pkg::ALT_BIT];
endmodule : icf_top
`default_nettype wire

// ### icf_pkg.sv
// package: register map, field positions and carrier types for the interrupt control block
package icf_pkg;
  localparam logic [3:0]  ADDR_CTRL1 = 4'h0;
  localparam logic [3:0]  ADDR_CTRL2 = 4'h4;
  localparam logic [3:0]  ADDR_FLAG0 = 4'h8;
  localparam logic [3:0]  ADDR_FLAG1 = 4'hC;
  localparam logic [4:0]  ADDR_FLAG2 = 5'h10;
  localparam logic [4:0]  ADDR_PRIO  = 5'h14;
  localparam logic [15:0] CTRL1_MASK = 16'h801E;
  localparam logic [15:0] CTRL2_WMASK = 16'h8007;
  localparam logic [15:0] FLAG0_MASK = 16'h3FEF;
  localparam logic [15:0] FLAG1_MASK = 16'hFE1F;
  localparam logic [15:0] FLAG2_MASK = 16'h22E3;
  localparam logic [15:0] RESET_VAL  = 16'h0000;
  localparam int          NEST_BIT   = 15;
  localparam int          ALT_BIT    = 15;
  localparam int          TDIS_BIT   = 14;
  localparam logic [2:0]  PRIO_RESET = 3'h0;

  typedef struct packed {
    logic arith;
    logic address;
    logic stack;
    logic osc_fail;
  } icf_trap_t;

  typedef struct packed {
    logic [15:0] flags0;
    logic [15:0] flags1;
    logic [15:0] flags2;
  } icf_flags_t;
endpackage : icf_pkg

// ### icf_chk.sv
// checker: bus timing and flag relations of the interrupt control bank
`timescale 1ns/1ps
`default_nettype none
module icf_chk (
  input wire logic                ref_clk,
  input wire logic                resetn,
  input wire logic [4:0]          avs_address,
  input wire logic                avs_read,
  input wire logic                avs_write,
  input wire logic [31:0]         avs_readdata,
  input wire logic                avs_waitrequest,
  input wire icf_pkg::icf_flags_t periph_req,
  input wire logic                nesting_disable,
  input wire logic [2:0]          cpu_priority_level,
  input wire icf_pkg::icf_flags_t pending_flags
);
  localparam logic [47:0] MSK = 48'h3FEF_FE1F_22E3;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  chk_wait_one: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state");
  chk_flag_set: assert property (|periph_req |=> (pending_flags & $past(periph_req)) ==
    ($past(periph_req) & MSK)) else $error("flag not set");
  chk_flag_hold: assert property (|($past(pending_flags) & ~pending_flags) |->
    $past(avs_write)) else $error("flag dropped");
  chk_pad_zero: assert property ((pending_flags & ~MSK) == 48'h0)
    else $error("pad bits");
  chk_ctrl1_pad: assert property (avs_read && !avs_waitrequest && avs_address == 5'h00 |=>
    avs_readdata[14:5] == 10'h0 && !avs_readdata[0]) else $error("ctrl pad");
  chk_read_hi: assert property (avs_read && !avs_waitrequest |=> avs_readdata[31:16] == 16'h0)
    else $error("upper half");
  chk_flag_read: assert property (avs_read && !avs_waitrequest && avs_address == 5'h08 |=>
    avs_readdata[15:0] == $past(pending_flags.flags0)) else $error("flag read");
  // priority must hold even across a write while nesting is off
  chk_prio_lock: assert property (nesting_disable |=> $stable(cpu_priority_level))
    else $error("priority changed");
  cover property (avs_write && !avs_waitrequest);
  cover property (|periph_req);
  cover property (nesting_disable && avs_write && avs_address == 5'h14);
endmodule : icf_chk
bind icf_top icf_chk chk_i (.*);
`default_nettype wire

// ### tb.sv
// testbench: register, trap, flag and edge tests over the slave bus
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk, resetn, avs_read, avs_write, avs_waitrequest, timed_disable_in;
  logic handler_active, new_irq_req, preempt_allow, alt_vector_select, nesting_disable;
  logic [4:0]          avs_address;
  logic [31:0]         avs_writedata, avs_readdata;
  logic [3:0]          avs_byteenable;
  logic [2:0]          ext_pin, cpu_priority_level;
  icf_pkg::icf_trap_t  trap_taken;
  icf_pkg::icf_flags_t periph_req, pending_flags;
  int                  num_errors, checks_done, i;
  logic [31:0]         m [7] = '{32'h801E, 32'hC007, 32'h3FEF, 32'hFE1F, 32'h22E3, 0, 0};
  icf_top dut (.*);
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) num_errors++;
    if (g !== e) $display("[ERR] %s exp %h got %h", n, e, g);
  endtask : ck
  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [31:0] e);
    @(posedge ref_clk);
    {avs_address, avs_writedata, avs_write, avs_read} <= {a, 16'h0, d, w, !w};
    // no wait count assumed; the watchdog ends a hung slave
    do @(negedge ref_clk); while (avs_waitrequest !== 1'b0);
    @(posedge ref_clk);
    {avs_read, avs_write} <= 2'b00;
    @(negedge ref_clk);
    if (!w) ck($sformatf("reg %h", a), e, avs_readdata);
  endtask : acc
  task summarize;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    #100000 num_errors++;
    summarize();
  end
  initial begin
    {ref_clk, resetn, avs_read, avs_write, handler_active, new_irq_req} = 0;
    {avs_address, avs_writedata, trap_taken, periph_req, ext_pin, timed_disable_in} = 0;
    avs_byteenable = 4'hF;
    repeat (10) @(posedge ref_clk);
    resetn <= 1;
    for (i = 0; i < 7; i++) acc(0, 5'(i * 4), 0, 0);
    timed_disable_in = 1;
    for (i = 0; i < 7; i++) acc(1, 5'(i * 4), 16'hFFFF, 0);
    for (i = 0; i < 7; i++) acc(0, 5'(i * 4), 0, m[i]);
    ck("alt", 1, alt_vector_select);
    {handler_active, new_irq_req} = 2'b11;
    #1 ck("preempt", 0, preempt_allow);
    $display("register test done");
    for (i = 0; i < 6; i++) acc(1, 5'(i * 4), 0, 0);
    #1 ck("preempt", 1, preempt_allow);
    acc(1, 5'h14, 16'h5, 0);
    for (i = 0; i < 6; i++) acc(0, 5'(i * 4), 0, i == 1 ? 32'h4000 : i / 5 * 5);
    for (i = 0; i < 4; i++) begin
      trap_taken = 4'h8 >> i;
      acc(0, 0, 0, 32'h1F & ~(32'hF >> i));
    end
    trap_taken = 0;
    $display("trap test done");
    periph_req = '1;
    acc(0, 8, 0, 32'h3FEF);
    periph_req = 0;
    acc(0, 12, 0, 32'hFE1F);
    acc(0, 16, 0, 32'h22E3);
    for (i = 0; i < 4; i++) begin
      acc(1, 4, i < 2 ? 16'h0 : 16'h7, 0);
      acc(1, 8, 0, 0);
      acc(1, 12, 0, 0);
      ext_pin = i[0] ? 3'h0 : 3'h7;
      repeat (3) @(posedge ref_clk);
      acc(0, 8, 0, 32'(i % 3 == 0));
      acc(0, 12, 0, i % 3 ? 32'h0 : 32'h2010);
    end
    $display("flag test done");
    summarize();
  end
endmodule : tb
`default_nettype wire
